// File: steer_fault_map.vh
// steer_fault_map.vh: constants for the steering fault supervisor
// Overview of operation
// [R1] overvoltage: code 18, latched immediate shutdown
// [R2] motor temp: code 21, reduced limit, self-clears
// [R3] controller overtemp: code 22, clears below 85C
// [R4] reversed polarity: code 23, latched shutdown
// [R5] 5V supply overload: code 24, latched hold-shutdown
// [R6] relay driver fault: code 31, latched warn-shutdown
// [R7] relay welded 32, not closed 33: shutdown
// [R8] hardware fault: code 34, latched shutdown
// [R9] motor stalled: code 36, latched shutdown
// [R10] motor open: code 37, latched warn-shutdown
// [R11] motor short: code 38, latched shutdown
// [R12] command input 1 range: code 41, hold-shutdown
// [R13] command input 2 or crosscheck: 42, hold-shutdown
// [R14] feedback input 1 range: code 43, hold-shutdown
// [R15] feedback input 2 or crosscheck: 44, hold-shutdown
// [R16] parameter memory crc: code 46, hold-shutdown
// [R17] encoder fault: code 47, warn-then-shutdown
// [R18] home not found: code 53, latched shutdown
// [R19] startup handshake failure: code 62, latched shutdown
// [R20] shutdown stops drive, drops fault output
// [R21] warn-shutdown runs until traction stop or timeout
// [R22] hold-shutdown holds wheel until stop or timeout
// [R23] blink active fault code on status led
// [R24] worst reaction wins, highest-priority code flashes
`ifndef STEER_FAULT_MAP_VH
`define STEER_FAULT_MAP_VH

// ==========================================
// fault indices into the detect vector
`define F_OVERVOLT 0
`define F_MOTOR_TEMP 1
`define F_CTRL_TEMP 2
`define F_POLARITY 3
`define F_SUPPLY_5V 4
`define F_RELAY_DRV 5
`define F_RELAY_WELD 6
`define F_RELAY_OPEN 7
`define F_HARDWARE 8
`define F_STALL 9
`define F_MOTOR_OPEN 10
`define F_MOTOR_SHORT 11
`define F_CMD1 12
`define F_CMD2 13
`define F_FB1 14
`define F_FB2 15
`define F_CRC 16
`define F_ENCODER 17
`define F_HOME 18
`define F_HANDSHAKE 19
`define N_DET 19
`define N_FAULT 20

// ==========================================
// reactions, numbered in rising severity
`define RX_NONE 3'h0
`define RX_WARN 3'h1
`define RX_CUR 3'h2
`define RX_WTS 3'h3
`define RX_HTS 3'h4
`define RX_SHUT 3'h5

// ==========================================
// temperatures and timing
`define CTRL_TEMP_CLEAR_C 8'h55
`define CLK_PERIOD_NS 10
`define MS_NS 1000000
`define TICKS_PER_MS (`MS_NS / `CLK_PERIOD_NS)
`define HS_WINDOW_MS 16'h0064
`define LED_ON_MS 250
`define LED_OFF_MS 250
`define LED_DIGIT_GAP_MS 1000
`define LED_REPEAT_GAP_MS 2000

`endif

// File: flash_code_blinker.v
// flash_code_blinker.v: blinks a two-digit bcd fault code on the led
`timescale 1ns/1ps
`default_nettype none
`include "steer_fault_map.vh"

module flash_code_blinker #(
  parameter integer ON_CYC = `LED_ON_MS * `TICKS_PER_MS,
  parameter integer OFF_CYC = `LED_OFF_MS * `TICKS_PER_MS,
  parameter integer DIGIT_GAP_CYC = `LED_DIGIT_GAP_MS * `TICKS_PER_MS,
  parameter integer REPEAT_GAP_CYC = `LED_REPEAT_GAP_MS * `TICKS_PER_MS
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // code to show, zero for none
  input wire [7:0] code,
  // led drive
  output reg led_r
);

  localparam [1:0] BL_IDLE = 2'h0;
  localparam [1:0] BL_ON = 2'h1;
  localparam [1:0] BL_OFF = 2'h2;
  localparam [1:0] BL_GAP = 2'h3;

  reg [1:0] state_r;
  reg [31:0] tmr_r;
  reg [7:0] shown_r;
  reg second_r;
  reg [3:0] left_r;

  // a code is sampled once per sequence so the pattern is never torn mid-digit
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= BL_IDLE;
      tmr_r <= 32'h0;
      shown_r <= 8'h00;
      second_r <= 1'b0;
      left_r <= 4'h0;
      led_r <= 1'b0;
    end else if (tmr_r != 32'h0) begin
      tmr_r <= tmr_r - 32'h1;
    end else begin
      case (state_r)
        BL_IDLE: begin
          led_r <= 1'b0;
          if (code != 8'h00) begin
            shown_r <= code;
            second_r <= 1'b0;
            left_r <= code[7:4];
            state_r <= BL_GAP;
          end
        end
        BL_ON: begin
          led_r <= 1'b0; // [R23]
          left_r <= left_r - 4'h1;
          tmr_r <= OFF_CYC[31:0];
          state_r <= BL_OFF;
        end
        BL_OFF: begin
          if (left_r != 4'h0) begin
            led_r <= 1'b1; // [R23]
            tmr_r <= ON_CYC[31:0];
            state_r <= BL_ON;
          end else if (!second_r) begin
            second_r <= 1'b1;
            left_r <= shown_r[3:0];
            tmr_r <= DIGIT_GAP_CYC[31:0];
            state_r <= BL_GAP;
          end else begin
            tmr_r <= REPEAT_GAP_CYC[31:0];
            state_r <= BL_IDLE;
          end
        end
        BL_GAP: begin
          if (left_r != 4'h0) begin
            led_r <= 1'b1; // [R23]
            tmr_r <= ON_CYC[31:0];
            state_r <= BL_ON;
          end else begin
            tmr_r <= OFF_CYC[31:0];
            state_r <= BL_OFF;
          end
        end
        default: begin
          state_r <= BL_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: steering_fault_supervisor.v
// steering_fault_supervisor.v: fault latching, reaction and flash code selection
`timescale 1ns/1ps
`default_nettype none
`include "steer_fault_map.vh"

module steering_fault_supervisor #(
  parameter integer TICKS_PER_MS = `TICKS_PER_MS,
  parameter [15:0] HS_WINDOW_MS = `HS_WINDOW_MS,
  parameter integer LED_ON_CYC = `LED_ON_MS * `TICKS_PER_MS,
  parameter integer LED_OFF_CYC = `LED_OFF_MS * `TICKS_PER_MS,
  parameter integer LED_DGAP_CYC = `LED_DIGIT_GAP_MS * `TICKS_PER_MS,
  parameter integer LED_RGAP_CYC = `LED_REPEAT_GAP_MS * `TICKS_PER_MS
) (
  // clock and key-switch power-up reset
  input wire clk_sys,
  input wire sys_rst,
  // key switch level, low while the key is off
  input wire key_switch_input,
  // detector levels, one per fault index except the handshake failure
  input wire [`N_DET-1:0] fault_det,
  // heatsink temperature in whole degrees
  input wire [7:0] heatsink_temp_c,
  // traction side
  input wire traction_stopped,
  input wire traction_hs_ack,
  output reg traction_hs_req_r,
  // configured fault steering timeout, ms
  input wire [15:0] fault_steer_timeout_ms,
  // steering reaction outputs
  output reg steer_enable_r,
  output reg fault_out_r,
  output reg hold_position_r,
  output reg warning_r,
  output reg current_reduce_r,
  output reg [7:0] active_code_r,
  // status led driver
  output wire status_led_r
);

  // ==========================================
  // fault table
  function [7:0] code_of;
    input [4:0] idx;
    begin
      case (idx)
        5'd0: code_of = 8'h18; // [R1]
        5'd1: code_of = 8'h21; // [R2]
        5'd2: code_of = 8'h22; // [R3]
        5'd3: code_of = 8'h23; // [R4]
        5'd4: code_of = 8'h24; // [R5]
        5'd5: code_of = 8'h31; // [R6]
        5'd6: code_of = 8'h32; // [R7]
        5'd7: code_of = 8'h33; // [R7]
        5'd8: code_of = 8'h34; // [R8]
        5'd9: code_of = 8'h36; // [R9]
        5'd10: code_of = 8'h37; // [R10]
        5'd11: code_of = 8'h38; // [R11]
        5'd12: code_of = 8'h41; // [R12]
        5'd13: code_of = 8'h42; // [R13]
        5'd14: code_of = 8'h43; // [R14]
        5'd15: code_of = 8'h44; // [R15]
        5'd16: code_of = 8'h46; // [R16]
        5'd17: code_of = 8'h47; // [R17]
        5'd18: code_of = 8'h53; // [R18]
        5'd19: code_of = 8'h62; // [R19]
        default: code_of = 8'h00;
      endcase
    end
  endfunction

  // unknown indices fail safe to an immediate stop
  function [2:0] react_of;
    input [4:0] idx;
    begin
      case (idx)
        5'd0: react_of = `RX_SHUT; // [R1]
        5'd1: react_of = `RX_CUR; // [R2]
        5'd2: react_of = `RX_CUR; // [R3]
        5'd3: react_of = `RX_SHUT; // [R4]
        5'd4: react_of = `RX_HTS; // [R5]
        5'd5: react_of = `RX_WTS; // [R6]
        5'd6: react_of = `RX_SHUT; // [R7]
        5'd7: react_of = `RX_SHUT; // [R7]
        5'd8: react_of = `RX_SHUT; // [R8]
        5'd9: react_of = `RX_SHUT; // [R9]
        5'd10: react_of = `RX_WTS; // [R10]
        5'd11: react_of = `RX_SHUT; // [R11]
        5'd12: react_of = `RX_HTS; // [R12]
        5'd13: react_of = `RX_HTS; // [R13]
        5'd14: react_of = `RX_HTS; // [R14]
        5'd15: react_of = `RX_HTS; // [R15]
        5'd16: react_of = `RX_HTS; // [R16]
        5'd17: react_of = `RX_WTS; // [R17]
        5'd18: react_of = `RX_SHUT; // [R18]
        5'd19: react_of = `RX_SHUT; // [R19]
        default: react_of = `RX_SHUT;
      endcase
    end
  endfunction

  // temperature faults recover on their own; all others wait for a key cycle
  function is_auto;
    input [4:0] idx;
    begin
      is_auto = (idx == `F_MOTOR_TEMP) || (idx == `F_CTRL_TEMP);
    end
  endfunction

  // ==========================================
  // key cycle and startup handshake
  localparam [1:0] HS_IDLE = 2'h0;
  localparam [1:0] HS_WAIT = 2'h1;
  localparam [1:0] HS_DONE = 2'h2;
  localparam [1:0] HS_FAIL = 2'h3;

  reg [1:0] hs_state_r;
  reg [1:0] hs_state_nxt;
  reg [15:0] hs_ms_r;
  reg [31:0] tick_cnt_r;
  reg ms_tick_r;
  wire key_off;
  wire hs_fail_set;

  assign key_off = ~key_switch_input;
  assign hs_fail_set = (hs_state_r == HS_FAIL);

  // free running millisecond tick shared by the handshake and reaction timers
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b0;
    end else if (tick_cnt_r >= TICKS_PER_MS - 1) begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      ms_tick_r <= 1'b0;
    end
  end

  always @* begin
    hs_state_nxt = hs_state_r;
    case (hs_state_r)
      HS_IDLE: begin
        if (!key_off) begin
          hs_state_nxt = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (traction_hs_ack) begin
          hs_state_nxt = HS_DONE;
        end else if (hs_ms_r >= HS_WINDOW_MS) begin
          hs_state_nxt = HS_FAIL; // [R19]
        end
      end
      HS_DONE, HS_FAIL: begin
        hs_state_nxt = hs_state_r;
      end
      default: begin
        hs_state_nxt = HS_IDLE;
      end
    endcase
    // a key cycle restarts the handshake from the beginning
    if (key_off) begin
      hs_state_nxt = HS_IDLE;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      hs_state_r <= HS_IDLE;
      hs_ms_r <= 16'h0000;
      traction_hs_req_r <= 1'b0;
    end else begin
      hs_state_r <= hs_state_nxt;
      traction_hs_req_r <= (hs_state_nxt == HS_WAIT); // [R19]
      if (hs_state_r != HS_WAIT) begin
        hs_ms_r <= 16'h0000;
      end else if (ms_tick_r && hs_ms_r != 16'hFFFF) begin
        hs_ms_r <= hs_ms_r + 16'h0001;
      end
    end
  end

  // ==========================================
  // fault flags
  wire [`N_FAULT-1:0] raw_det;
  reg [`N_FAULT-1:0] fault_r;

  assign raw_det = {hs_fail_set, fault_det};

  genvar gi;
  generate
    for (gi = 0; gi < `N_FAULT; gi = gi + 1) begin : g_flag
      if (gi == `F_MOTOR_TEMP) begin : g_follow
        // estimated motor temperature back in range drops the flag
        always @(posedge clk_sys) begin
          if (sys_rst) begin
            fault_r[gi] <= 1'b0;
          end else begin
            fault_r[gi] <= raw_det[gi]; // [R2]
          end
        end
      end else if (gi == `F_CTRL_TEMP) begin : g_hyst
        // stays set until the heatsink is below the clear point
        always @(posedge clk_sys) begin
          if (sys_rst) begin
            fault_r[gi] <= 1'b0;
          end else if (raw_det[gi]) begin
            fault_r[gi] <= 1'b1; // [R3]
          end else if (heatsink_temp_c < `CTRL_TEMP_CLEAR_C) begin
            fault_r[gi] <= 1'b0; // [R3]
          end
        end
      end else begin : g_latch
        // detection wins over a key-off clear in the same cycle
        always @(posedge clk_sys) begin
          if (sys_rst) begin
            fault_r[gi] <= 1'b0;
          end else if (raw_det[gi]) begin
            fault_r[gi] <= 1'b1; // [R1] [R4] [R8] [R9] [R11] [R18]
          end else if (key_off) begin
            fault_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========================================
  // worst reaction and displayed code
  reg [2:0] worst;
  reg [7:0] sel_code;
  reg any_cur;
  integer k;

  // scan downward so the lowest index wins a tie of equal severity
  always @* begin
    worst = `RX_NONE;
    sel_code = 8'h00;
    any_cur = 1'b0;
    for (k = `N_FAULT - 1; k >= 0; k = k - 1) begin
      if (fault_r[k]) begin
        if (react_of(k[4:0]) >= worst) begin
          worst = react_of(k[4:0]); // [R24]
          sel_code = code_of(k[4:0]); // [R24]
        end
        // only the self-clearing temperature faults trim the current limit
        if (is_auto(k[4:0])) begin
          any_cur = 1'b1;
        end
      end
    end
  end

  // ==========================================
  // reaction sequencer
  localparam [1:0] RS_RUN = 2'h0;
  localparam [1:0] RS_DELAY = 2'h1;
  localparam [1:0] RS_SHUT = 2'h2;

  reg [1:0] rs_state_r;
  reg [1:0] rs_state_nxt;
  reg [15:0] rs_ms_r;
  wire delay_over;

  // either end condition closes the grace period
  assign delay_over = traction_stopped || (rs_ms_r >= fault_steer_timeout_ms); // [R21] [R22]

  always @* begin
    rs_state_nxt = rs_state_r;
    case (rs_state_r)
      RS_RUN: begin
        if (worst == `RX_SHUT) begin
          rs_state_nxt = RS_SHUT; // [R20]
        end else if (worst == `RX_WTS || worst == `RX_HTS) begin
          rs_state_nxt = RS_DELAY;
        end
      end
      RS_DELAY: begin
        if (worst == `RX_SHUT || delay_over) begin
          rs_state_nxt = RS_SHUT; // [R21] [R22]
        end else if (worst < `RX_WTS) begin
          rs_state_nxt = RS_RUN;
        end
      end
      RS_SHUT: begin
        // leaves only once the latched causes were cleared by a key cycle
        if (worst < `RX_WTS) begin
          rs_state_nxt = RS_RUN;
        end
      end
      default: begin
        rs_state_nxt = RS_SHUT;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rs_state_r <= RS_RUN;
      rs_ms_r <= 16'h0000;
      steer_enable_r <= 1'b0;
      fault_out_r <= 1'b0;
      hold_position_r <= 1'b0;
      warning_r <= 1'b0;
      current_reduce_r <= 1'b0;
      active_code_r <= 8'h00;
    end else begin
      rs_state_r <= rs_state_nxt;
      if (rs_state_r != RS_DELAY) begin
        rs_ms_r <= 16'h0000;
      end else if (ms_tick_r && rs_ms_r != 16'hFFFF) begin
        rs_ms_r <= rs_ms_r + 16'h0001;
      end
      // drive stays off while the key is off or until the handshake completes
      steer_enable_r <= (rs_state_nxt != RS_SHUT) && (hs_state_r == HS_DONE); // [R20]
      fault_out_r <= (rs_state_nxt != RS_SHUT); // [R20]
      hold_position_r <= (rs_state_nxt == RS_DELAY) && (worst == `RX_HTS); // [R22]
      warning_r <= (worst != `RX_NONE); // [R21]
      current_reduce_r <= any_cur; // [R2] [R3]
      active_code_r <= sel_code; // [R24]
    end
  end

  // ==========================================
  // status led
  flash_code_blinker #(
    .ON_CYC(LED_ON_CYC),
    .OFF_CYC(LED_OFF_CYC),
    .DIGIT_GAP_CYC(LED_DGAP_CYC),
    .REPEAT_GAP_CYC(LED_RGAP_CYC)
  ) u_blinker (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .code(active_code_r),
    .led_r(status_led_r) // [R23]
  );

endmodule
`default_nettype wire

// File: steer_sup_props.sv
// checker for the steering fault supervisor ports
`timescale 1ns/1ps
`default_nettype none
`include "steer_fault_map.vh"
// ==========================================
// reaction, latching and handshake checks
module steer_sup_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // inputs
  input wire logic key_switch_input,
  input wire logic [`N_DET-1:0] fault_det,
  input wire logic [7:0] heatsink_temp_c,
  input wire logic traction_stopped,
  input wire logic traction_hs_ack,
  input wire logic [15:0] fault_steer_timeout_ms,
  // outputs
  input wire logic traction_hs_req_r,
  input wire logic steer_enable_r,
  input wire logic fault_out_r,
  input wire logic hold_position_r,
  input wire logic warning_r,
  input wire logic current_reduce_r,
  input wire logic [7:0] active_code_r
);
  // detectors that stop the drive at once: codes 18 23 32 33 34 36 38 53
  localparam logic [18:0] SHUT_MASK = 19'h40BC9;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_SHUT_NOW: assert property ((fault_det & SHUT_MASK) != 19'h0
    |-> ##2 (!fault_out_r && !steer_enable_r)) else $error("drive left on");
  AST_LATCH_18: assert property (active_code_r == 8'h18 && key_switch_input
    |=> active_code_r == 8'h18) else $error("code 18 lost with key on");
  AST_SELF_CLEAR: assert property ((active_code_r == 8'h21 && fault_det == 19'h2
    && heatsink_temp_c < 8'h55) ##1 (fault_det == 19'h0 && heatsink_temp_c < 8'h55) [*2]
    |=> (active_code_r == 8'h00 && !current_reduce_r)) else $error("code 21 stuck");
  AST_TEMP_HOLD: assert property ((active_code_r == 8'h22 && heatsink_temp_c >= 8'h55
    && fault_det == 19'h0) ##1 (heatsink_temp_c >= 8'h55 && fault_det == 19'h0)
    |=> (active_code_r == 8'h22 && current_reduce_r)) else $error("code 22 cleared hot");
  AST_WTS_RUNS: assert property ($rose(warning_r) && active_code_r == 8'h31
    && $past(steer_enable_r) && !traction_stopped && fault_steer_timeout_ms > 16'h0001
    |-> (steer_enable_r && fault_out_r) [*2]) else $error("warn stage cut short");
  AST_HOLD: assert property ($rose(warning_r) && active_code_r == 8'h24
    && !traction_stopped |-> ##[0:1] hold_position_r) else $error("wheel not held");
  AST_STOP_SHUT: assert property (warning_r && traction_stopped
    && active_code_r >= 8'h24 |-> ##[0:3] (!steer_enable_r && !fault_out_r))
    else $error("no shutdown after traction stop");
  AST_HS_DONE: assert property (traction_hs_req_r && traction_hs_ack
    && fault_det == 19'h0 && !warning_r |-> ##1 !traction_hs_req_r ##1 steer_enable_r)
    else $error("handshake answer not taken");
  AST_HS_FAIL: assert property ($fell(traction_hs_req_r) && !$past(traction_hs_ack)
    && key_switch_input && !warning_r && fault_det == 19'h0
    |-> ##[1:3] active_code_r == 8'h62) else $error("handshake failure not shown");
endmodule
bind steering_fault_supervisor steer_sup_props u_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .key_switch_input(key_switch_input),
  .fault_det(fault_det), .heatsink_temp_c(heatsink_temp_c),
  .traction_stopped(traction_stopped), .traction_hs_ack(traction_hs_ack),
  .fault_steer_timeout_ms(fault_steer_timeout_ms), .traction_hs_req_r(traction_hs_req_r),
  .steer_enable_r(steer_enable_r), .fault_out_r(fault_out_r),
  .hold_position_r(hold_position_r), .warning_r(warning_r),
  .current_reduce_r(current_reduce_r), .active_code_r(active_code_r)
);
`default_nettype wire

// File: traction_partner.sv
// traction controller model: startup handshake and motor stop
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// partner model
module traction_partner (
  // clock
  input wire logic clk_sys,
  // handshake
  input wire logic hs_req,
  input wire logic answer,
  input wire logic slow,
  output logic hs_ack,
  // traction motor
  input wire logic stop_cmd,
  output logic stopped
);
  logic [3:0] cnt_r;
  initial begin
    cnt_r = 4'h0;
    hs_ack = 1'b0;
    stopped = 1'b0;
  end
  // answer only while asked, so a late ack never lands outside the wait
  always @(posedge clk_sys) begin
    cnt_r <= (hs_req && cnt_r != 4'hF) ? cnt_r + 4'h1 : (hs_req ? cnt_r : 4'h0);
    hs_ack <= answer && hs_req && cnt_r >= (slow ? 4'h9 : 4'h2);
    stopped <= stop_cmd;
  end
endmodule
`default_nettype wire

// File: tb_steering_fault_supervisor.sv
// self-checking bench for the steering fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "steer_fault_map.vh"
// ==========================================
// bench top
module tb_steering_fault_supervisor;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic key_switch_input = 1'b1;
  logic [`N_DET-1:0] fault_det = 19'h0;
  logic [7:0] heatsink_temp_c = 8'h19;
  logic [15:0] fault_steer_timeout_ms = 16'h0003;
  logic answer = 1'b1;
  logic slow = 1'b1;
  logic stop_cmd = 1'b0;
  logic traction_stopped, traction_hs_ack, traction_hs_req_r, steer_enable_r, fault_out_r;
  logic hold_position_r, warning_r, current_reduce_r, status_led_r;
  logic [7:0] active_code_r;
  int bad_count = 0;
  int n_tests = 0;
  int sh_idx[8] = '{0, 3, 6, 7, 8, 9, 11, 18};
  logic [7:0] sh_code[8] = '{8'h18, 8'h23, 8'h32, 8'h33, 8'h34, 8'h36, 8'h38, 8'h53};
  int dl_idx[9] = '{5, 10, 17, 4, 12, 13, 14, 15, 16};
  logic [7:0] dl_code[9] = '{8'h31, 8'h37, 8'h47, 8'h24, 8'h41, 8'h42, 8'h43, 8'h44, 8'h46};
  always #5 clk_sys = ~clk_sys;
  // short counts keep the blink pattern inside the run; the handshake window keeps its default
  steering_fault_supervisor #(.TICKS_PER_MS(10), .LED_ON_CYC(5),
    .LED_OFF_CYC(5), .LED_DGAP_CYC(20), .LED_RGAP_CYC(40)) u_steering_fault_supervisor (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .key_switch_input(key_switch_input),
    .fault_det(fault_det), .heatsink_temp_c(heatsink_temp_c),
    .traction_stopped(traction_stopped), .traction_hs_ack(traction_hs_ack),
    .traction_hs_req_r(traction_hs_req_r), .fault_steer_timeout_ms(fault_steer_timeout_ms),
    .steer_enable_r(steer_enable_r), .fault_out_r(fault_out_r),
    .hold_position_r(hold_position_r), .warning_r(warning_r),
    .current_reduce_r(current_reduce_r), .active_code_r(active_code_r),
    .status_led_r(status_led_r));
  traction_partner u_traction_partner (.clk_sys(clk_sys), .hs_req(traction_hs_req_r),
    .answer(answer), .slow(slow), .hs_ack(traction_hs_ack), .stop_cmd(stop_cmd),
    .stopped(traction_stopped));
  // ==========================================
  // shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task conclude;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task await(input bit s);
    int k;
    for (k = 0; k < 1200; k++) begin
      @(negedge clk_sys);
      if (s ? active_code_r === 8'h62 : steer_enable_r === 1'b1) return;
    end
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    bad_count++;
    conclude();
  endtask
  task key_cycle(input bit s);
    @(negedge clk_sys);
    key_switch_input = 1'b0;
    cyc(2);
    key_switch_input = 1'b1;
    await(s);
  endtask
  task hit(input logic [18:0] m);
    @(negedge clk_sys);
    fault_det = m;
    @(negedge clk_sys);
    fault_det = 19'h0;
    cyc(2);
  endtask
  task grp(output int n);
    int k, lo;
    bit pv;
    n = 0;
    lo = 0;
    pv = 1'b0;
    for (k = 0; k < 300; k++) begin
      @(negedge clk_sys);
      if (status_led_r === 1'b1 && !pv) n++;
      pv = (status_led_r === 1'b1);
      lo = pv ? 0 : lo + 1;
      if (n > 0 && lo >= 12) break;
    end
  endtask
  // ==========================================
  // scenarios
  task t_led;
    int n, k, lo;
    lo = 0;
    for (k = 0; k < 300 && lo < 30; k++) begin
      @(negedge clk_sys);
      lo = (status_led_r === 1'b1) ? 0 : lo + 1;
    end
    grp(n);
    chk(n, 1);
    grp(n);
    chk(n, 8);
  endtask
  task t_temp;
    fault_det[1] = 1'b1;
    cyc(3);
    chk({current_reduce_r, warning_r, steer_enable_r, active_code_r}, {3'b111, 8'h21});
    fault_det[1] = 1'b0;
    cyc(4);
    chk({current_reduce_r, warning_r, active_code_r}, 10'h0);
    heatsink_temp_c = 8'h5A;
    fault_det[2] = 1'b1;
    cyc(3);
    fault_det[2] = 1'b0;
    cyc(5);
    chk({current_reduce_r, active_code_r}, {1'b1, 8'h22});
    heatsink_temp_c = 8'h55;
    cyc(5);
    chk({current_reduce_r, active_code_r}, {1'b1, 8'h22});
    heatsink_temp_c = 8'h54;
    cyc(4);
    chk({current_reduce_r, active_code_r}, 9'h0);
  endtask
  task t_shut;
    int k;
    for (k = 0; k < 8; k++) begin
      key_cycle(1'b0);
      hit(19'h1 << sh_idx[k]);
      chk({fault_out_r, steer_enable_r}, 2'b00);
      chk(active_code_r, sh_code[k]);
      cyc(6);
      chk(active_code_r, sh_code[k]);
      if (k == 0) t_led();
    end
  endtask
  task t_delay;
    int k;
    for (k = 0; k < 9; k++) begin
      key_cycle(1'b0);
      hit(19'h1 << dl_idx[k]);
      chk({steer_enable_r, fault_out_r, hold_position_r, warning_r},
        {2'b11, k >= 3, 1'b1});
      chk(active_code_r, dl_code[k]);
      if (k % 2 == 1) begin
        stop_cmd = 1'b1;
        cyc(5);
        stop_cmd = 1'b0;
      end else begin
        // the ms tick may land early, so stay well inside the grace time
        cyc(15);
        chk(steer_enable_r, 1'b1);
        cyc(30);
      end
      chk({steer_enable_r, fault_out_r, hold_position_r}, 3'b000);
    end
    // a zero grace time shuts down after a single cycle in the delay stage
    fault_steer_timeout_ms = 16'h0000;
    key_cycle(1'b0);
    hit(19'h1 << 5);
    chk({fault_out_r, steer_enable_r, active_code_r}, {2'b00, 8'h31});
    fault_steer_timeout_ms = 16'h0003;
  endtask
  task t_prio;
    key_cycle(1'b0);
    hit(19'h01022);
    chk({hold_position_r, active_code_r}, {1'b1, 8'h41});
    hit(19'h00208);
    chk({fault_out_r, active_code_r}, {1'b0, 8'h23});
  endtask
  task t_hs_fail;
    answer = 1'b0;
    key_cycle(1'b1);
    chk({fault_out_r, steer_enable_r}, 2'b00);
    cyc(5);
    chk(active_code_r, 8'h62);
    answer = 1'b1;
    key_cycle(1'b0);
    chk({fault_out_r, active_code_r}, {1'b1, 8'h00});
  endtask
  // ==========================================
  // main sequence
  initial begin
    cyc(6);
    sys_rst = 1'b0;
    await(1'b0);
    chk({fault_out_r, active_code_r}, {1'b1, 8'h00});
    chk(traction_hs_req_r, 1'b0);
    slow = 1'b0;
    t_temp();
    t_shut();
    t_delay();
    t_prio();
    t_hs_fail();
    conclude();
  end
endmodule
`default_nettype wire
